// file: smc_pkg.sv
// Constants for the standby mode controller
// Summary of operation
// - A slow oscillator that runs when stop is entered keeps running through the stop state.
// - The stabilization wait after stop is counted only from the start of oscillation.
// - The wait after power-up or reset comes from the nonvolatile option setting.
// - A pending unmasked interrupt on entry to either standby state causes immediate wake-up.
// - An immediate wake-up after stop holds operation about 34 us, plus the programmed wait for a resonator.
// - While reset is asserted both the system oscillator and the slow oscillator are stopped.
// - Software halt of the slow oscillator takes effect only when the option setting allows it.
package smc_pkg;
  localparam int  CLK_MHZ          = 20;
  localparam int  HOLD_NS          = 34000;
  localparam int  HOLD_CYC         = HOLD_NS * CLK_MHZ / 1000;
  localparam int  EXT_RST_NS       = 2000;
  localparam int  EXT_RST_CYC      = (EXT_RST_NS * CLK_MHZ + 999) / 1000;
  localparam int  SEL_W            = 3;
  localparam int  CNT_W            = 20;
  localparam int  BASE_SHIFT       = 10;
  localparam int  SHIFT_STEP       = 1;
  localparam int  OSC_START_CYC    = 4;
  localparam logic [7:0] RESET_OUT = 8'h00;
  typedef enum logic [2:0] {
    SMC_RUN, SMC_HALT, SMC_STOP, SMC_HOLD, SMC_WAIT, SMC_RSTWAIT
  } smc_state_t;
endpackage : smc_pkg

// file: smc_counter.sv
// Down-counter used for hold and stabilization waits
`timescale 1ns/100ps
`default_nettype none
module smc_counter #(
  parameter int W = 20
) (
  input  wire logic         i_sys_clk,  // System clock
  input  wire logic         i_reset,    // Async reset, high
  input  wire logic         i_load,     // Load start value
  input  wire logic [W-1:0] i_value,    // Start value
  input  wire logic         i_enable,   // Count enable
  output logic              o_done      // Count reached zero
);
  logic [W-1:0] count;
  wire          at_zero = (count == '0);
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      count  <= '0;
      o_done <= 1'b0;
    end
    else if (i_load)
    begin
      count  <= i_value;
      o_done <= 1'b0;
    end
    else if (i_enable)
    begin
      count  <= at_zero ? count : count - 1'b1;
      o_done <= at_zero;
    end
  end
endmodule : smc_counter
`default_nettype wire

// file: smc_standby.sv
// Standby controller: halt and stop entry, wake-up and stabilization wait
`timescale 1ns/100ps
`default_nettype none
module smc_standby #(
  parameter int HOLD_CYC = smc_pkg::HOLD_CYC,
  parameter int OSC_START_CYC = smc_pkg::OSC_START_CYC
) (
  input  wire logic                     i_sys_clk,        // 20 MHz clock
  input  wire logic                     i_reset,          // Async reset, high
  input  wire logic                     i_reset_pin_n,    // External reset pin, low
  input  wire logic                     i_halt_instr,     // Core executes halt, pulse
  input  wire logic                     i_stop_instr,     // Core executes stop, pulse
  input  wire logic                     i_irq_pending,    // Any request set and unmasked
  input  wire logic [smc_pkg::SEL_W-1:0] i_stab_time_select, // Run-time wait select
  input  wire logic [smc_pkg::SEL_W-1:0] i_option_stab_sel,  // Option wait select
  input  wire logic                     i_option_slow_stoppable, // Option allows halt
  input  wire logic                     i_slow_osc_halt_control, // Software halt request
  input  wire logic                     i_resonator,      // Crystal/ceramic in use
  output logic                          o_cpu_clk_en,     // Processor clock gate
  output logic                          o_main_osc_en,    // System oscillator enable
  output logic                          o_slow_osc_en,    // Slow oscillator enable
  output logic                          o_int_reset,      // Internal reset to core
  output logic                          o_in_standby      // Halt or stop active
);
  localparam int CW = smc_pkg::CNT_W;
  logic [1:0] pin_sync;
  logic       pin_low;
  logic [7:0] pin_cnt;
  logic       ext_rst;
  smc_pkg::smc_state_t state, next_state;
  logic       slow_run;
  logic [4:0] osc_cnt;
  logic       osc_started;
  logic       hold_done;

  // Pin synchroniser and minimum-width filter
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
      pin_sync <= 2'h3;
    else
      pin_sync <= {pin_sync[0], i_reset_pin_n};
  end
  assign pin_low = ~pin_sync[1];
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      pin_cnt <= 8'h00;
      ext_rst <= 1'b0;
    end
    else if (!pin_low)
    begin
      pin_cnt <= 8'h00;
      ext_rst <= 1'b0;
    end
    else if (pin_cnt >= 8'(smc_pkg::EXT_RST_CYC - 1))
      ext_rst <= 1'b1;
    else
      pin_cnt <= pin_cnt + 8'h01;
  end

  wire rst_any = ext_rst;
  wire in_stop = (state == smc_pkg::SMC_STOP);

  // Wait length select: option after reset, register after stop
  wire                      use_opt  = (state == smc_pkg::SMC_RSTWAIT);
  wire [smc_pkg::SEL_W-1:0] sel      = use_opt ? i_option_stab_sel : i_stab_time_select;
  wire [smc_pkg::CNT_W-1:0] stab_val = CW'(1) << (smc_pkg::BASE_SHIFT + 32'(sel));
  wire [smc_pkg::CNT_W-1:0] hold_val = CW'(HOLD_CYC);

  // Oscillation start detection: counting begins after this delay
  wire osc_on = o_main_osc_en;
  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      osc_cnt     <= 5'h00;
      osc_started <= 1'b0;
    end
    else if (!osc_on)
    begin
      osc_cnt     <= 5'h00;
      osc_started <= 1'b0;
    end
    else if (osc_cnt >= 5'(OSC_START_CYC))
      osc_started <= 1'b1;
    else
      osc_cnt <= osc_cnt + 5'h01;
  end

  wire enter_wait = (state == smc_pkg::SMC_HOLD) && hold_done && i_resonator;
  wire load_hold  = (state != smc_pkg::SMC_HOLD) && (next_state == smc_pkg::SMC_HOLD);
  // Reset wait keeps reloading until the oscillator has started
  wire load_stab  = enter_wait || ((state != smc_pkg::SMC_RSTWAIT) && rst_any) ||
                    (use_opt && !osc_started);
  wire cnt_load   = load_hold || load_stab;
  wire [smc_pkg::CNT_W-1:0] cnt_val = load_hold ? hold_val : stab_val;
  wire cnt_en     = osc_started;

  smc_counter #(.W(smc_pkg::CNT_W)) u_cnt (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_load    (cnt_load),
    .i_value   (cnt_val),
    .i_enable  (cnt_en),
    .o_done    (hold_done)
  );

  always_comb
  begin
    next_state = state;
    case (state)
      smc_pkg::SMC_RUN:
        if (rst_any)
          next_state = smc_pkg::SMC_RSTWAIT;
        else if (i_stop_instr)
          next_state = i_irq_pending ? smc_pkg::SMC_HOLD : smc_pkg::SMC_STOP;
        else if (i_halt_instr && !i_irq_pending)
          next_state = smc_pkg::SMC_HALT;
      smc_pkg::SMC_HALT:
        if (rst_any)
          next_state = smc_pkg::SMC_RSTWAIT;
        else if (i_irq_pending)
          next_state = smc_pkg::SMC_RUN;
      smc_pkg::SMC_STOP:
        if (rst_any)
          next_state = smc_pkg::SMC_RSTWAIT;
        else if (i_irq_pending)
          next_state = smc_pkg::SMC_HOLD;
      smc_pkg::SMC_HOLD:
        if (rst_any)
          next_state = smc_pkg::SMC_RSTWAIT;
        else if (hold_done)
          next_state = i_resonator ? smc_pkg::SMC_WAIT : smc_pkg::SMC_RUN;
      smc_pkg::SMC_WAIT:
        if (rst_any)
          next_state = smc_pkg::SMC_RSTWAIT;
        else if (hold_done)
          next_state = smc_pkg::SMC_RUN;
      smc_pkg::SMC_RSTWAIT:
        if (!rst_any && hold_done)
          next_state = smc_pkg::SMC_RUN;
      default:
        next_state = smc_pkg::SMC_RSTWAIT;
    endcase
  end

  // Slow oscillator: software halt only when option allows; kept through stop
  wire slow_halt_ok = i_option_slow_stoppable && i_slow_osc_halt_control;
  wire next_slow    = rst_any ? 1'b0 :
                      in_stop ? slow_run :
                      !slow_halt_ok;

  always_ff @(posedge i_sys_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      state         <= smc_pkg::SMC_RSTWAIT;
      slow_run      <= 1'b0;
      o_cpu_clk_en  <= 1'b0;
      o_main_osc_en <= 1'b0;
      o_slow_osc_en <= 1'b0;
      o_int_reset   <= 1'b1;
      o_in_standby  <= 1'b0;
    end
    else
    begin
      state         <= next_state;
      slow_run      <= next_slow;
      o_slow_osc_en <= next_slow;
      o_main_osc_en <= !rst_any && (next_state != smc_pkg::SMC_STOP);
      o_cpu_clk_en  <= (next_state == smc_pkg::SMC_RUN);
      o_int_reset   <= rst_any || (next_state == smc_pkg::SMC_RSTWAIT);
      o_in_standby  <= (next_state == smc_pkg::SMC_HALT) || (next_state == smc_pkg::SMC_STOP);
    end
  end

  AST_CLK_GATED_IN_WAIT: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (state == smc_pkg::SMC_WAIT) |-> !o_cpu_clk_en) else $error("clock ungated in wait");
  AST_SLOW_KEPT_STOP: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (in_stop && slow_run && !rst_any) |=> slow_run) else $error("slow osc halted in stop");
  AST_RESET_STOPS_OSC: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    rst_any |=> (!o_main_osc_en && !o_slow_osc_en)) else $error("osc runs in reset");
  AST_HALT_NEEDS_OPTION: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (!rst_any && !in_stop && !i_option_slow_stoppable) |=> slow_run)
    else $error("slow osc halted without option");
  AST_IMMEDIATE_WAKE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (state == smc_pkg::SMC_RUN && i_halt_instr && i_irq_pending && !rst_any) |=>
    (state == smc_pkg::SMC_RUN)) else $error("halt entered with pending irq");
  AST_STOP_HOLDS: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (state == smc_pkg::SMC_RUN && i_stop_instr && i_irq_pending && !rst_any) |=>
    (state == smc_pkg::SMC_HOLD) ##1 !o_cpu_clk_en) else $error("no hold after stop");
  AST_COUNT_AFTER_OSC: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    !osc_started |=> !hold_done || $past(hold_done)) else $error("count before osc");
  AST_RSTWAIT_OPTION: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (state == smc_pkg::SMC_RSTWAIT) |-> (sel == i_option_stab_sel))
    else $error("reset wait not from option");
  // Stop release walk: hold with the oscillator on, then the resonator wait
  sequence s_stop_release;
    (state == smc_pkg::SMC_STOP) && i_irq_pending && !rst_any;
  endsequence
  sequence s_in_hold;
    (state == smc_pkg::SMC_HOLD) && !o_cpu_clk_en && o_main_osc_en;
  endsequence
  sequence s_hold_entry;
    (state != smc_pkg::SMC_HOLD) && (next_state == smc_pkg::SMC_HOLD);
  endsequence
  sequence s_hold_to_wait;
    (state == smc_pkg::SMC_HOLD) && hold_done && i_resonator && !rst_any;
  endsequence
  AST_STOP_RELEASE_HOLD: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    s_stop_release |=> s_in_hold) else $error("stop release skipped hold");
  // Assumes a hold count of eight cycles or more
  AST_HOLD_LEN: assert property (@(posedge i_sys_clk) disable iff (i_reset || rst_any)
    s_hold_entry |=> (state == smc_pkg::SMC_HOLD) [*8]) else $error("hold ended early");
  AST_WAIT_AFTER_HOLD: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    s_hold_to_wait |=> (state == smc_pkg::SMC_WAIT) ##1 !o_cpu_clk_en)
    else $error("resonator wait skipped");
  AST_HALT_ENTRY: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (state == smc_pkg::SMC_RUN && i_halt_instr && !i_stop_instr && !i_irq_pending && !rst_any)
    |=> (o_in_standby && !o_cpu_clk_en)) else $error("halt not entered");
  AST_HALT_WAKE: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (state == smc_pkg::SMC_HALT && i_irq_pending && !rst_any) |=> o_cpu_clk_en)
    else $error("halt not released by irq");
endmodule : smc_standby
`default_nettype wire

// file: smc_core_model.sv
// Processor core model that issues halt and stop instructions
`timescale 1ns/100ps
`default_nettype none
module smc_core_model (
  input  wire logic i_sys_clk,    // System clock
  input  wire logic i_cpu_clk_en, // Processor clock gate
  output logic      o_halt_instr, // Halt pulse
  output logic      o_stop_instr  // Stop pulse
);
  initial
  begin
    o_halt_instr = 1'b0;
    o_stop_instr = 1'b0;
  end
  // Peripherals and converter are already quiesced when this is called
  task automatic execute(input logic stop);
    @(posedge i_sys_clk);
    while (i_cpu_clk_en !== 1'b1) @(posedge i_sys_clk);
    #1;
    if (stop) o_stop_instr = 1'b1;
    else o_halt_instr = 1'b1;
    @(posedge i_sys_clk);
    #1;
    o_stop_instr = 1'b0;
    o_halt_instr = 1'b0;
  endtask : execute
endmodule : smc_core_model
`default_nettype wire

// file: test_standby_mode_controller.sv
// Testbench for the standby controller
`timescale 1ns/100ps
`default_nettype none
module test_standby_mode_controller;
  localparam int HOLD = 20;
  localparam int OSC  = 4;
  logic       clk, rst, pin_n, irq, stoppable, slowctl, reson;
  logic       halt, stop, cpu_en, mosc, sosc, irst, stby;
  logic [2:0] sel, osel;
  int         fails, checks_done, cycles;
  smc_core_model smc_core_model_i (.i_sys_clk(clk), .i_cpu_clk_en(cpu_en),
    .o_halt_instr(halt), .o_stop_instr(stop));
  smc_standby #(.HOLD_CYC(HOLD), .OSC_START_CYC(OSC)) smc_standby_i (
    .i_sys_clk(clk), .i_reset(rst), .i_reset_pin_n(pin_n), .i_halt_instr(halt),
    .i_stop_instr(stop), .i_irq_pending(irq), .i_stab_time_select(sel),
    .i_option_stab_sel(osel), .i_option_slow_stoppable(stoppable),
    .i_slow_osc_halt_control(slowctl), .i_resonator(reson), .o_cpu_clk_en(cpu_en),
    .o_main_osc_en(mosc), .o_slow_osc_en(sosc), .o_int_reset(irst), .o_in_standby(stby));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic results;
    if (fails == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Counts cycles until the processor clock returns and checks the window
  task automatic wait_en(input int lo, input int hi);
    int n;
    n = 0;
    while (cpu_en !== 1'b1 && n <= hi)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n >= lo && n <= hi, 1'b1);
  endtask : wait_en
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles > 20000)
    begin
      fails++;
      results();
    end
  end
  initial
  begin
    fails = 0; checks_done = 0; cycles = 0;
    rst = 1'b1; pin_n = 1'b1; irq = 1'b0; stoppable = 1'b0; slowctl = 1'b0;
    reson = 1'b1; sel = 3'h0; osel = 3'h1;
    step(6);
    chk({cpu_en, mosc, sosc, irst, stby}, 5'h02);
    rst = 1'b0;
    wait_en(2048, 2048 + OSC + 8);
    chk(irst, 1'b0);
    // Halt with pending request is refused, then real halt and wake
    irq = 1'b1;
    smc_core_model_i.execute(1'b0);
    step(1);
    chk({stby, cpu_en}, 2'h1);
    irq = 1'b0;
    smc_core_model_i.execute(1'b0);
    chk({stby, cpu_en}, 2'h2);
    step(3);
    irq = 1'b1;
    wait_en(1, 1);
    irq = 1'b0;
    // Stop with resonator: slow oscillator keeps running
    step(2);
    smc_core_model_i.execute(1'b1);
    step(1);
    chk({stby, cpu_en, mosc, sosc}, 4'h9);
    step(10);
    irq = 1'b1;
    wait_en(HOLD + 1024, HOLD + 1024 + OSC + 8);
    // Immediate wake after stop without resonator waits only the hold
    reson = 1'b0;
    smc_core_model_i.execute(1'b1);
    wait_en(HOLD, HOLD + OSC + 8);
    irq = 1'b0;
    // Software halt of slow oscillator only when the option allows it
    slowctl = 1'b1;
    step(3);
    chk(sosc, 1'b1);
    stoppable = 1'b1;
    step(3);
    chk(sosc, 1'b0);
    slowctl = 1'b0;
    step(3);
    chk(sosc, 1'b1);
    // External pin reset held beyond the minimum width
    pin_n = 1'b0;
    step(45);
    chk({cpu_en, mosc, sosc, irst}, 4'h1);
    pin_n = 1'b1;
    wait_en(2048, 2048 + OSC + 16);
    results();
  end
endmodule : test_standby_mode_controller
`default_nettype wire
